// ===== usbic_pkg.sv
// Shared constants and types for the hub microcontroller interrupt controller
package usbic_pkg;
	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 8;
	localparam int          PC_W           = 13;
	localparam int          NUM_SRC        = 12;
	localparam int          NUM_EP         = 5;
	localparam int          NUM_PORT       = 4;
	localparam int          NUM_GPIO       = 11;
	localparam int          GPIO_P0_W      = 8;
	localparam logic [7:0]  OFS_GLOBAL_EN  = 8'h20;
	localparam logic [7:0]  OFS_EP_EN      = 8'h21;
	localparam logic [7:0]  OFS_DAC_EN     = 8'h22;
	localparam logic [7:0]  OFS_STATUS     = 8'hff;
	localparam logic [7:0]  GLOBAL_EN_MASK = 8'h6f;
	localparam logic [7:0]  EP_EN_MASK     = 8'h1f;
	localparam logic [7:0]  DAC_EN_MASK    = 8'h01;
	localparam logic [7:0]  STATUS_WR_MASK = 8'h7b;
	localparam logic [7:0]  STATUS_RESET   = 8'h11;
	localparam int          ST_IRQ_PEND    = 7;
	localparam int          ST_BUS_RESET   = 5;
	localparam int          ST_IE_SENSE    = 2;
	localparam int          GE_BUS_RESET   = 0;
	localparam int          GE_T128        = 1;
	localparam int          GE_T1024       = 2;
	localparam int          GE_HUB         = 3;
	localparam int          GE_GPIO        = 5;
	localparam int          GE_I2C         = 6;
	localparam int          SRC_BUS_RESET  = 0;
	localparam int          SRC_T128       = 1;
	localparam int          SRC_T1024      = 2;
	localparam int          SRC_EP_BASE    = 3;
	localparam int          SRC_HUB        = 8;
	localparam int          SRC_DAC        = 9;
	localparam int          SRC_GPIO       = 10;
	localparam int          SRC_I2C        = 11;
	localparam int          CLK_MHZ        = 10;
	localparam int          SE0_MIN_NS     = 12000;
	localparam int          SE0_MAX_NS     = 16000;
	localparam int          SE0_CYCLES     = (SE0_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int          CALL_CYCLES    = 10;
	localparam logic [3:0]  CALL_LAST      = 4'(CALL_CYCLES - 1);
	localparam logic [7:0]  SE0_LAST       = 8'(SE0_CYCLES - 1);
	typedef struct packed {
		logic [PC_W-1:0] pc;
		logic            carry_flag;
		logic            zero_flag;
	} usbic_stack_t;
	typedef struct packed {
		logic [NUM_PORT-1:0] connectChange;
		logic [NUM_PORT-1:0] portForced;
		logic [NUM_PORT-1:0] babble;
		logic [NUM_PORT-1:0] resumeDetect;
		logic [NUM_PORT-1:0] portEnable;
	} usbic_hub_t;
	typedef enum logic [0:0] {
		CALL_IDLE = 1'b0,
		CALL_RUN  = 1'b1
	} usbic_call_t;
endpackage : usbic_pkg

// ===== usbic_controller.sv
// Interrupt controller with its sources, register port and vector call sequencer
//
// Behaviour
// - Endpoint enable register, bits 0-4 used
// - Reset clears all three interrupt enable registers
// - One pending flop per source, sticky
// - Request only when pending and enabled
// - Accept only at instruction completion
// - Clear global enable, pending, then call
// - Call pushes program counter, carry, zero
// - Return restores state, sets global enable
// - Enable/disable instructions touch global enable
// - Status bit 7 shows pending enabled request
// - Lowest vector number wins arbitration
// - Vector n at address 2n, reset zero
// - Vector call takes ten clock cycles
// - Both data lines low 12us is reset
// - Bus reset sets status, clears hub registers
// - Bus reset pending latched when SE0 ends
// - Bus reset aborts start-up delay
// - Endpoint events only on final ACK
// - Hub events: connect, babble, resume gated
// - Forced ports give no connect interrupt
// - All GPIO pins share one vector
// - GPIO lockout until pin inactive or disabled
// - Global source enable register, bits 4,7 reserved
`timescale 1ns/1ps
`default_nettype none
module usbic_controller (
	input  wire logic                                clk,
	input  wire logic                                resetn,
	input  wire logic [usbic_pkg::ADDR_W-1:0]        regAddr,
	input  wire logic [usbic_pkg::DATA_W-1:0]        regWdata,
	input  wire logic                                regWr,
	input  wire logic                                regRd,
	output logic      [usbic_pkg::DATA_W-1:0]        regRdata,
	input  wire logic                                instrDone,
	input  wire logic                                eiExec,
	input  wire logic                                diExec,
	input  wire logic                                retiExec,
	input  wire usbic_pkg::usbic_stack_t             cpuState,
	input  wire usbic_pkg::usbic_stack_t             popData,
	output usbic_pkg::usbic_stack_t                  pushData,
	output logic                                     pushValid,
	output usbic_pkg::usbic_stack_t                  restoreData,
	output logic                                     restoreValid,
	output logic                                     globalIe,
	output logic                                     callBusy,
	output logic                                     vectorCall,
	output logic      [15:0]                         vectorAddr,
	input  wire logic                                upDplus,
	input  wire logic                                upDminus,
	input  wire logic                                startupDelayActive,
	output logic                                     startupAbort,
	output logic                                     addrRegClear,
	output logic                                     hubRegClear,
	input  wire logic                                tick128,
	input  wire logic                                tick1024,
	input  wire logic [usbic_pkg::NUM_EP-1:0]        epInHostAck,
	input  wire logic [usbic_pkg::NUM_EP-1:0]        epOutDevAck,
	input  wire usbic_pkg::usbic_hub_t               hubStatus,
	input  wire logic                                dacEvent,
	input  wire logic                                i2cEvent,
	input  wire logic [usbic_pkg::NUM_GPIO-1:0]      gpioPin,
	input  wire logic [usbic_pkg::NUM_GPIO-1:0]      gpioPinEnable,
	input  wire logic [1:0]                          gpioPolarity
);
	logic [7:0]                      globalEn;
	logic [7:0]                      epEn;
	logic [7:0]                      dacEn;
	logic [7:0]                      statusCtl;
	logic [usbic_pkg::NUM_SRC-1:0]   pending;
	logic [usbic_pkg::NUM_SRC-1:0]   srcEnable;
	logic [usbic_pkg::NUM_SRC-1:0]   srcSet;
	logic [usbic_pkg::NUM_SRC-1:0]   irqReq;
	logic [usbic_pkg::NUM_SRC-1:0]   acceptMask;
	logic [3:0]                      winIdx;
	logic                            anyReq;
	logic                            accept;
	usbic_pkg::usbic_call_t          callState;
	logic [3:0]                      callCount;
	logic [3:0]                      callIdx;
	logic                            se0;
	logic [7:0]                      se0Count;
	logic                            busResetSeen;
	logic                            busResetDetect;
	logic                            busResetEnd;
	logic                            hubEvent;
	logic [usbic_pkg::NUM_GPIO-1:0]  gpioActive;
	logic [usbic_pkg::NUM_GPIO-1:0]  gpioActivePrev;
	logic [usbic_pkg::NUM_GPIO-1:0]  gpioRise;
	logic [usbic_pkg::NUM_GPIO-1:0]  gpioLock;
	logic [usbic_pkg::NUM_GPIO-1:0]  next_gpioLock;
	logic                            gpioTrigger;
	logic [7:0]                      regRead;

	// Source enables in vector order
	assign srcEnable = {globalEn[usbic_pkg::GE_I2C], globalEn[usbic_pkg::GE_GPIO], dacEn[0],
		globalEn[usbic_pkg::GE_HUB], epEn[usbic_pkg::NUM_EP-1:0], globalEn[usbic_pkg::GE_T1024],
		globalEn[usbic_pkg::GE_T128], globalEn[usbic_pkg::GE_BUS_RESET]};
	assign irqReq = pending & srcEnable;
	assign anyReq = |irqReq;

	// Lowest index wins
	always_comb begin
		winIdx = 4'h0;
		for (int i = usbic_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (irqReq[i]) begin
				winIdx = 4'(i);
			end
		end
	end

	// Taken only on an instruction boundary, never mid-instruction
	assign accept = instrDone && globalIe && anyReq && (callState == usbic_pkg::CALL_IDLE);
	assign acceptMask = accept ? (usbic_pkg::NUM_SRC'(1) << winIdx) : '0;

	// Upstream bus reset: SE0 counted from the minimum time
	assign se0 = !upDplus && !upDminus;
	assign busResetDetect = se0 && !busResetSeen && (se0Count == usbic_pkg::SE0_LAST);
	assign busResetEnd = !se0 && busResetSeen;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			se0Count <= 8'h00;
		end else if (!se0) begin
			se0Count <= 8'h00;
		end else if (se0Count != usbic_pkg::SE0_LAST) begin
			se0Count <= se0Count + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busResetSeen <= 1'b0;
		end else if (busResetDetect) begin
			busResetSeen <= 1'b1;
		end else if (busResetEnd) begin
			busResetSeen <= 1'b0;
		end
	end

	// Registers outside this block are cleared by these pulses
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addrRegClear <= 1'b0;
			hubRegClear  <= 1'b0;
			startupAbort <= 1'b0;
		end else begin
			addrRegClear <= busResetDetect;
			hubRegClear  <= busResetDetect;
			startupAbort <= busResetDetect && startupDelayActive;
		end
	end

	// Hub change events; forced ports report no connect change
	assign hubEvent = |(hubStatus.connectChange & ~hubStatus.portForced)
		| |((hubStatus.babble | hubStatus.resumeDetect) & hubStatus.portEnable);

	// GPIO trigger detection, one vector for all pins
	genvar g;
	generate
		for (g = 0; g < usbic_pkg::NUM_GPIO; g++) begin : gen_gpio
			localparam int PORT = (g < usbic_pkg::GPIO_P0_W) ? 0 : 1;
			assign gpioActive[g] = gpioPinEnable[g] && (gpioPin[g] == gpioPolarity[PORT]);
		end
	endgenerate
	assign gpioRise = gpioActive & ~gpioActivePrev;

	// Lock holds the lowest-numbered pin that fired; it blocks all others until released
	always_comb begin
		next_gpioLock = gpioLock;
		gpioTrigger   = 1'b0;
		if (|gpioLock) begin
			if ((gpioLock & gpioActive) == '0) begin
				next_gpioLock = '0;
			end
		end else if (|gpioRise) begin
			gpioTrigger   = 1'b1;
			next_gpioLock = gpioRise & (~gpioRise + usbic_pkg::NUM_GPIO'(1));
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gpioLock       <= '0;
			gpioActivePrev <= '0;
		end else begin
			gpioLock       <= next_gpioLock;
			gpioActivePrev <= gpioActive;
		end
	end

	// Source events in vector order
	assign srcSet = {i2cEvent, gpioTrigger, dacEvent, hubEvent,
		epInHostAck | epOutDevAck, tick1024, tick128, busResetEnd};

	// A new event wins over the clear at acceptance
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pending <= '0;
		end else begin
			pending <= (pending & ~acceptMask) | srcSet;
		end
	end

	// Global enable bit of the CPU
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			globalIe <= 1'b0;
		end else if (accept) begin
			globalIe <= 1'b0;
		end else if (retiExec || eiExec) begin
			globalIe <= 1'b1;
		end else if (diExec) begin
			globalIe <= 1'b0;
		end
	end

	// Call sequencer: push at acceptance, vector after the full call time
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			callState  <= usbic_pkg::CALL_IDLE;
			callCount  <= 4'h0;
			callIdx    <= 4'h0;
			vectorCall <= 1'b0;
			vectorAddr <= 16'h0000;
			callBusy   <= 1'b0;
		end else begin
			vectorCall <= 1'b0;
			unique case (callState)
				usbic_pkg::CALL_IDLE: begin
					if (accept) begin
						callState <= usbic_pkg::CALL_RUN;
						callCount <= 4'h1;
						callIdx   <= winIdx;
						callBusy  <= 1'b1;
					end
				end
				usbic_pkg::CALL_RUN: begin
					if (callCount == usbic_pkg::CALL_LAST) begin
						callState  <= usbic_pkg::CALL_IDLE;
						callBusy   <= 1'b0;
						vectorCall <= 1'b1;
						vectorAddr <= {11'h000, callIdx + 4'h1, 1'b0};
					end else begin
						callCount <= callCount + 4'h1;
					end
				end
			endcase
		end
	end

	// Only the program counter and two flags travel through the stack
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pushData     <= '0;
			pushValid    <= 1'b0;
			restoreData  <= '0;
			restoreValid <= 1'b0;
		end else begin
			pushValid    <= accept;
			restoreValid <= retiExec;
			if (accept) begin
				pushData <= cpuState;
			end
			if (retiExec) begin
				restoreData <= popData;
			end
		end
	end

	// Enable registers; reserved bits never store
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			globalEn <= 8'h00;
			epEn     <= 8'h00;
			dacEn    <= 8'h00;
		end else if (regWr) begin
			if (regAddr == usbic_pkg::OFS_GLOBAL_EN) begin
				globalEn <= regWdata & usbic_pkg::GLOBAL_EN_MASK;
			end
			if (regAddr == usbic_pkg::OFS_EP_EN) begin
				epEn <= regWdata & usbic_pkg::EP_EN_MASK;
			end
			if (regAddr == usbic_pkg::OFS_DAC_EN) begin
				dacEn <= regWdata & usbic_pkg::DAC_EN_MASK;
			end
		end
	end

	// Status register; a detected bus reset wins over a software clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			statusCtl <= usbic_pkg::STATUS_RESET;
		end else begin
			if (regWr && regAddr == usbic_pkg::OFS_STATUS) begin
				statusCtl <= regWdata & usbic_pkg::STATUS_WR_MASK;
			end
			if (busResetDetect) begin
				statusCtl[usbic_pkg::ST_BUS_RESET] <= 1'b1;
			end
		end
	end

	always_comb begin
		regRead = 8'h00;
		unique case (regAddr)
			usbic_pkg::OFS_GLOBAL_EN: regRead = globalEn;
			usbic_pkg::OFS_EP_EN:     regRead = epEn;
			usbic_pkg::OFS_DAC_EN:    regRead = dacEn;
			usbic_pkg::OFS_STATUS: begin
				regRead = statusCtl;
				regRead[usbic_pkg::ST_IRQ_PEND] = anyReq;
				regRead[usbic_pkg::ST_IE_SENSE] = globalIe;
			end
			default:                  regRead = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			regRdata <= 8'h00;
		end else begin
			regRdata <= regRd ? regRead : 8'h00;
		end
	end

	property p_accept_clears_ie;
		@(posedge clk) disable iff (!resetn) accept |=> !globalIe;
	endproperty
	a_accept_clears_ie: assert property (p_accept_clears_ie) else $error("global enable kept after accept");

	property p_call_latency;
		@(posedge clk) disable iff (!resetn) accept |=> (!vectorCall)[*8] ##1 !vectorCall ##1 vectorCall;
	endproperty
	a_call_latency: assert property (p_call_latency) else $error("vector call not ten cycles after accept");

	property p_vector_addr;
		logic [3:0] idx;
		@(posedge clk) disable iff (!resetn) (accept, idx = winIdx) |-> ##10 (vectorAddr == {11'h000, idx + 4'h1, 1'b0});
	endproperty
	a_vector_addr: assert property (p_vector_addr) else $error("vector address not twice the vector number");

	property p_pending_cleared;
		logic [3:0] idx;
		@(posedge clk) disable iff (!resetn) (accept && !srcSet[winIdx], idx = winIdx) |=> !pending[idx];
	endproperty
	a_pending_cleared: assert property (p_pending_cleared) else $error("serviced pending flag not cleared");

	property p_priority;
		@(posedge clk) disable iff (!resetn) accept |-> ((irqReq & ((usbic_pkg::NUM_SRC'(1) << winIdx) - 1'b1)) == '0);
	endproperty
	a_priority: assert property (p_priority) else $error("lower vector number was passed over");

	property p_no_accept_mid_instr;
		@(posedge clk) disable iff (!resetn) $rose(callBusy) |-> $past(instrDone) && $past(globalIe);
	endproperty
	a_no_accept_mid_instr: assert property (p_no_accept_mid_instr) else $error("call started off an instruction boundary");

	property p_return_from_handler_instruction_sets_ie;
		@(posedge clk) disable iff (!resetn) (retiExec && !accept) |=> globalIe && restoreValid && restoreData == $past(popData);
	endproperty
	a_return_from_handler_instruction_sets_ie: assert property (p_return_from_handler_instruction_sets_ie) else $error("return did not restore state and enable");

	property p_bus_reset_end;
		@(posedge clk) disable iff (!resetn) (busResetSeen && !se0) |=> pending[usbic_pkg::SRC_BUS_RESET] && !busResetSeen;
	endproperty
	a_bus_reset_end: assert property (p_bus_reset_end) else $error("bus reset not latched at end of SE0");

	property p_bus_reset_status;
		@(posedge clk) disable iff (!resetn) busResetDetect |=> statusCtl[usbic_pkg::ST_BUS_RESET] && hubRegClear && addrRegClear;
	endproperty
	a_bus_reset_status: assert property (p_bus_reset_status) else $error("bus reset side effects missing");

	property p_gpio_lockout;
		@(posedge clk) disable iff (!resetn)
			(|gpioLock && |(gpioLock & gpioActive)) |-> !gpioTrigger ##1 (gpioLock == $past(gpioLock));
	endproperty
	a_gpio_lockout: assert property (p_gpio_lockout) else $error("gpio trigger during lockout");
endmodule : usbic_controller
`default_nettype wire

// ===== usbic_cpu_model.sv
// Behavioural CPU sequencer and program stack facing the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module usbic_cpu_model (
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic                    callBusy,
	input  wire logic                    pushValid,
	input  wire logic                    vectorCall,
	input  wire logic                    retiExec,
	input  wire usbic_pkg::usbic_stack_t pushData,
	input  wire logic [15:0]             vectorAddr,
	output logic                         instrDone,
	output usbic_pkg::usbic_stack_t      cpuState,
	output usbic_pkg::usbic_stack_t      popData
);
	logic [1:0]              phase;
	logic [2:0]              sp;
	usbic_pkg::usbic_stack_t stack [8];
	// Core stalls while the call runs, so no instruction ends mid-call
	assign instrDone = (phase == 2'h3) && !callBusy;
	// Only eight levels: deeper nesting silently wraps
	assign popData = stack[sp - 3'h1];
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			phase <= 2'h0;
		else if (!callBusy)
			phase <= phase + 2'h1;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			cpuState <= '0;
		else if (vectorCall)
			cpuState.pc <= vectorAddr[12:0];
		else if (retiExec)
			cpuState <= popData;
		else if (instrDone) begin
			cpuState.pc <= cpuState.pc + 13'h0001;
			cpuState.carry_flag <= ~cpuState.carry_flag;
			cpuState.zero_flag <= cpuState.pc[0];
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			sp <= 3'h0;
		else if (pushValid) begin
			stack[sp] <= pushData;
			sp <= sp + 3'h1;
		end else if (retiExec)
			sp <= sp - 3'h1;
	end
endmodule : usbic_cpu_model
`default_nettype wire

// ===== usb_hub_mcu_interrupt_controller_tb.sv
// Self-checking testbench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module usb_hub_mcu_interrupt_controller_tb;
	logic                    clk, resetn, regWr, regRd, eiExec, diExec, retiExec;
	logic                    upDplus, upDminus, startupDelayActive, instrDone, pushValid;
	logic                    restoreValid, globalIe, callBusy, vectorCall, startupAbort;
	logic                    addrRegClear, hubRegClear;
	logic [7:0]              regAddr, regWdata, regRdata, rv;
	logic [11:0]             evt;
	logic [10:0]             gpioPin, gpioEn;
	logic [1:0]              gpioPol;
	logic [15:0]             vectorAddr;
	usbic_pkg::usbic_hub_t   hubS;
	usbic_pkg::usbic_stack_t cpuState, popData, pushData, restoreData, lastPush;
	int                      err_count, n_compared, cyc, tPush, tCall, nAbort, nAddr, nHub;
	int                      srcs [8] = '{1, 3, 4, 5, 6, 7, 9, 11};

	usbic_controller uut (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .instrDone(instrDone), .eiExec(eiExec),
		.diExec(diExec), .retiExec(retiExec), .cpuState(cpuState), .popData(popData),
		.pushData(pushData), .pushValid(pushValid), .restoreData(restoreData),
		.restoreValid(restoreValid), .globalIe(globalIe), .callBusy(callBusy),
		.vectorCall(vectorCall), .vectorAddr(vectorAddr), .upDplus(upDplus), .upDminus(upDminus),
		.startupDelayActive(startupDelayActive), .startupAbort(startupAbort),
		.addrRegClear(addrRegClear), .hubRegClear(hubRegClear), .tick128(evt[1]),
		.tick1024(evt[2]), .epInHostAck(evt[7:3] & 5'h07), .epOutDevAck(evt[7:3] & 5'h18),
		.hubStatus(hubS), .dacEvent(evt[9]), .i2cEvent(evt[11]), .gpioPin(gpioPin),
		.gpioPinEnable(gpioEn), .gpioPolarity(gpioPol));
	usbic_cpu_model cpu (.clk(clk), .resetn(resetn), .callBusy(callBusy), .pushValid(pushValid),
		.vectorCall(vectorCall), .retiExec(retiExec), .pushData(pushData),
		.vectorAddr(vectorAddr), .instrDone(instrDone), .cpuState(cpuState), .popData(popData));

	always #50 clk = ~clk;
	// Event log so pulses are never missed between reads
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (pushValid === 1'b1) begin
			tPush <= cyc;
			lastPush <= pushData;
		end
		if (vectorCall === 1'b1)
			tCall <= cyc;
		if (startupAbort === 1'b1)
			nAbort <= nAbort + 1;
		if (addrRegClear === 1'b1)
			nAddr <= nAddr + 1;
		if (hubRegClear === 1'b1)
			nHub <= nHub + 1;
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		rv = regRdata;
	endtask : rd
	// Instruction pulse: 0 enable, 1 disable, 2 return from handler
	task automatic ins(input int k);
		@(posedge clk);
		eiExec <= (k == 0);
		diExec <= (k == 1);
		retiExec <= (k == 2);
		@(posedge clk);
		{eiExec, diExec, retiExec} <= 3'h0;
		#1;
	endtask : ins
	task automatic fire(input logic [11:0] m);
		@(posedge clk);
		evt <= m;
		@(posedge clk);
		evt <= 12'h000;
	endtask : fire
	task automatic waitCall(input logic [15:0] va);
		for (int i = 0; i < 100; i++) begin
			@(posedge clk);
			#1;
			if (vectorCall === 1'b1)
				break;
		end
		chk("vectorCall", {15'h0, vectorCall}, 16'h0001);
		chk("vectorAddr", vectorAddr, va);
		chk("globalIe", {15'h0, globalIe}, 16'h0000);
		chk("callBusy", {15'h0, callBusy}, 16'h0000);
	endtask : waitCall
	task automatic serve(input logic [15:0] va);
		ins(0);
		waitCall(va);
		ins(2);
		// The push log is updated one edge after acceptance
		chk("latency", 16'(tCall - tPush), 16'h0009);
		chk("restoreValid", {15'h0, restoreValid}, 16'h0001);
		chk("restoreData", 16'(restoreData), 16'(lastPush));
		chk("globalIe", {15'h0, globalIe}, 16'h0001);
		ins(1);
		chk("globalIe", {15'h0, globalIe}, 16'h0000);
	endtask : serve
	task automatic conclude;
		if (err_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		conclude();
	end
	initial begin
		{clk, resetn, regWr, regRd, eiExec, diExec, retiExec, upDminus} = '0;
		{cyc, tPush, tCall, nAbort, nAddr, nHub, err_count, n_compared} = '0;
		{regAddr, regWdata, evt, gpioPin, hubS} = '0;
		upDplus = 1'b1;
		gpioEn = 11'h7ff;
		gpioPol = 2'h3;
		startupDelayActive = 1'b1;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		rd(8'h20); chk("globalEn", 16'(rv), 16'h0000);
		rd(8'h21); chk("epEn", 16'(rv), 16'h0000);
		rd(8'hff); chk("status", 16'(rv), 16'h0011);
		rd(8'h33); chk("unmapped", 16'(rv), 16'h0000);
		fire(12'h004);
		rd(8'hff); chk("irqPend", 16'(rv[7]), 16'h0000);
		wr(8'h20, 8'hff); rd(8'h20); chk("globalEn", 16'(rv), 16'h006f);
		rd(8'hff); chk("irqPend", 16'(rv[7]), 16'h0001);
		serve(16'h0006);
		wr(8'h21, 8'hff); rd(8'h21); chk("epEn", 16'(rv), 16'h001f);
		wr(8'h22, 8'h01);
		foreach (srcs[j]) begin
			fire(12'h001 << srcs[j]);
			rd(8'hff); chk("irqPend", 16'(rv[7]), 16'h0001);
			serve(16'(2 * (srcs[j] + 1)));
		end
		// Three sources at once must come out in vector order
		fire(12'h814);
		ins(0); waitCall(16'h0006);
		ins(2); waitCall(16'h000a);
		ins(2); waitCall(16'h0018);
		ins(2); ins(1);
		// SE0 of 10 us is too short to count as a bus reset
		@(posedge clk) {upDplus, upDminus} <= 2'b00;
		repeat (100) @(posedge clk);
		upDplus <= 1'b1;
		rd(8'hff); chk("shortSe0", 16'({nAddr[7:0], rv[7]}), 16'h0000);
		@(posedge clk) upDplus <= 1'b0;
		repeat (125) @(posedge clk);
		chk("abort", 16'(nAbort), 16'h0001);
		chk("clears", 16'({nAddr[7:0], nHub[7:0]}), 16'h0101);
		rd(8'hff); chk("busRst", 16'(rv[7:5]), 16'h0001);
		@(posedge clk) upDplus <= 1'b1;
		rd(8'hff); chk("irqPend", 16'(rv[7]), 16'h0001);
		serve(16'h0002);
		// Forced connect change and babble on a disabled port are ignored
		@(posedge clk) hubS <= '{connectChange: 4'h1, portForced: 4'h1, babble: 4'h2, default: 4'h0};
		@(posedge clk) hubS <= '{portForced: 4'h1, default: 4'h0};
		rd(8'hff); chk("hubIgnored", 16'(rv[7]), 16'h0000);
		@(posedge clk) hubS <= '{resumeDetect: 4'h4, portEnable: 4'h4, default: 4'h0};
		@(posedge clk) hubS <= '{portEnable: 4'h4, default: 4'h0};
		rd(8'hff); chk("hubResume", 16'(rv[7]), 16'h0001);
		serve(16'h0012);
		@(posedge clk) gpioPin <= 11'h001;
		rd(8'hff); chk("gpioPend", 16'(rv[7]), 16'h0001);
		serve(16'h0016);
		@(posedge clk) gpioPin <= 11'h021;
		rd(8'hff); chk("gpioLocked", 16'(rv[7]), 16'h0000);
		@(posedge clk) gpioPin <= 11'h000;
		repeat (2) @(posedge clk);
		gpioPin <= 11'h020;
		rd(8'hff); chk("gpioRelease", 16'(rv[7]), 16'h0001);
		serve(16'h0016);
		// Disabling the locked pin frees the lock; port 1 then turned active low fires
		@(posedge clk) gpioEn <= 11'h7df;
		@(posedge clk) gpioPol <= 2'h1;
		rd(8'hff); chk("gpioPolarity", 16'(rv[7]), 16'h0001);
		serve(16'h0016);
		wr(8'hff, 8'h84); rd(8'hff); chk("statusWr", 16'(rv), 16'h0000);
		conclude();
	end
endmodule : usb_hub_mcu_interrupt_controller_tb
`default_nettype wire
